//--- shared/agd_pkg.sv
// constants shared by the access guard controller and its write checker
package agd_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int AGD_AW = 8;
	localparam int AGD_DW = 32;
	localparam int AGD_IDX_W = 5;
	localparam logic [AGD_AW-1:0] AGD_OFF_PROTECT_CLEAR = 8'h00;
	localparam logic [AGD_AW-1:0] AGD_OFF_PROTECT_SET = 8'h04;
	localparam logic [AGD_DW-1:0] AGD_PROT_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// guard bit positions of the first controller
	// ----------------------------------------------------------------
	localparam int AGD_EXT_IRQ_UNIT_GUARD_BIT = 6;
	localparam int AGD_RTC_GUARD_BIT = 5;
	localparam int AGD_WATCHDOG_GUARD_BIT = 4;
	localparam int AGD_GENERIC_CLOCK_GUARD_BIT = 3;
	localparam int AGD_SYSTEM_CONTROL_GUARD_BIT = 2;
	localparam int AGD_POWER_MANAGER_GUARD_BIT = 1;
	localparam logic [AGD_DW-1:0] AGD_MASK0 =
		(32'h1 << AGD_EXT_IRQ_UNIT_GUARD_BIT) |
		(32'h1 << AGD_RTC_GUARD_BIT) |
		(32'h1 << AGD_WATCHDOG_GUARD_BIT) |
		(32'h1 << AGD_GENERIC_CLOCK_GUARD_BIT) |
		(32'h1 << AGD_SYSTEM_CONTROL_GUARD_BIT) |
		(32'h1 << AGD_POWER_MANAGER_GUARD_BIT);

	// ----------------------------------------------------------------
	// register port phases
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		AGD_IDLE = 1'b0,
		AGD_RESP = 1'b1
	} agd_phase_e;

endpackage : agd_pkg

//--- shared/agd_chk_if.sv
// carrier between the controller and its peripheral write checker
`timescale 1ns/1ps
interface agd_chk_if;
	import agd_pkg::*;
	logic req;
	logic wr;
	logic dbg;
	logic [AGD_IDX_W-1:0] idx;
	logic [AGD_DW-1:0] prot;
	logic ok;
	logic err;
	modport ctrl (output req, output wr, output dbg, output idx,
		output prot, input ok, input err);
	modport chk (input req, input wr, input dbg, input idx,
		input prot, output ok, output err);
endinterface : agd_chk_if

//--- rtl/agd_check.sv
// answers each peripheral access with pass or access error
`timescale 1ns/1ps
module agd_check
	import agd_pkg::*;
(
	input wire logic clk, // bus clock
	input wire logic nrst, // sync reset, active low
	agd_chk_if.chk c // request and answer
);

	logic blocked;
	logic ok_q;
	logic err_q;

	// debugger traffic never looks at the guard bits
	assign blocked = c.wr && !c.dbg && c.prot[c.idx]; // R6 R9

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ok_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ok_q <= c.req && !blocked;
			err_q <= c.req && blocked; // R6 R15
		end
	end

	assign c.ok = ok_q;
	assign c.err = err_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	guarded_write_err_a: assert property (@(posedge clk) disable iff (!nrst) // R6
		c.req && c.wr && !c.dbg && c.prot[c.idx] |=> c.err && !c.ok)
		else $error("write to guarded peripheral not refused");
	debug_bypass_a: assert property (@(posedge clk) disable iff (!nrst) // R9
		c.req && c.dbg |=> c.ok && !c.err)
		else $error("debugger access was refused");

endmodule : agd_check

//--- rtl/agd_ctrl.sv
// access guard controller: per-peripheral write protection on one bridge
`timescale 1ns/1ps

// Contract
// R1: one guard bit per peripheral on bridge
// R2: clear write of one unprotects peripheral
// R3: set write of one protects peripheral
// R4: both registers read same protection vector
// R5: zero bits in writes change nothing
// R6: guarded non-debug write discarded, error returned
// R7: protecting already protected bit reports error
// R8: unprotecting unprotected bit reports error
// R9: debugger accesses ignore all protection
// R10: keeps working in sleep while clocked
// R11: bus clock enable reset value per instance
// R12: byte, halfword and word accesses supported
// R13: first controller bit layout, reset zero
// R14: software pairs protect and unprotect
// R15: errors returned as slave error response
module agd_ctrl
	import agd_pkg::*;
#(
	parameter logic [AGD_DW-1:0] IMPL_MASK = AGD_MASK0,
	parameter bit CLK_ON_RST = 1'b1
) (
	input wire logic clk, // bus clock
	input wire logic nrst, // sync reset, active low
	input wire logic psel, // register select
	input wire logic penable, // access phase
	input wire logic pwrite, // 1 write, 0 read
	input wire logic [AGD_AW-1:0] paddr, // byte address
	input wire logic [AGD_DW-1:0] pwdata, // write data
	input wire logic [3:0] pstrb, // byte lanes
	input wire logic pdebug, // access comes from debugger
	output logic [AGD_DW-1:0] prdata, // read data
	output logic pready, // transfer done
	output logic pslverr, // transfer error
	input wire logic guard_bus_clock_on, // enable from power manager
	output logic guard_bus_clock, // current bus clock enable
	input wire logic per_req, // peripheral access strobe
	input wire logic per_write, // peripheral access is a write
	input wire logic per_debug, // peripheral access from debugger
	input wire logic [AGD_IDX_W-1:0] per_idx, // peripheral index
	output logic per_ok, // access may proceed
	output logic per_err, // access refused
	output logic [AGD_DW-1:0] prot_bits // protection vector
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	agd_phase_e state_q;
	agd_phase_e state_d;
	logic [AGD_DW-1:0] prot_q;
	logic [AGD_DW-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic clk_on_q;

	logic acc;
	logic hit_clr;
	logic hit_set;
	logic mapped;
	logic [AGD_DW-1:0] lane_mask;
	logic [AGD_DW-1:0] wmask;
	logic dbl_set;
	logic dbl_clr;
	logic err_now;

	agd_chk_if chk_bus ();

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// one access per transfer: the access phase is taken once, then the
	// answer cycle holds pready high for exactly one edge
	assign acc = psel && penable && (state_q == AGD_IDLE);

	always_comb begin
		hit_clr = 1'b0;
		hit_set = 1'b0;
		if (paddr == AGD_OFF_PROTECT_CLEAR) begin
			hit_clr = 1'b1;
		end else if (paddr == AGD_OFF_PROTECT_SET) begin
			hit_set = 1'b1;
		end
	end
	assign mapped = hit_clr || hit_set;

	// byte and halfword writes only touch their own lanes
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign lane_mask[8*g +: 8] = {8{pstrb[g]}}; // R12
		end
	endgenerate

	// unimplemented bits are neither stored nor checked
	assign wmask = pwdata & lane_mask & IMPL_MASK; // R1 R5 R13

	assign dbl_set = hit_set && ((wmask & prot_q) != '0); // R7
	assign dbl_clr = hit_clr && ((wmask & ~prot_q) != '0); // R8

	always_comb begin
		err_now = 1'b0;
		if (!mapped || !clk_on_q) begin
			err_now = 1'b1;
		end else if (pwrite && !pdebug && (dbl_set || dbl_clr)) begin
			err_now = 1'b1; // R7 R8 R9
		end
	end

	// ----------------------------------------------------------------
	// transfer phase
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			AGD_IDLE: begin
				if (acc) begin
					state_d = AGD_RESP;
				end
			end
			AGD_RESP: begin
				state_d = AGD_IDLE;
			end
			default: begin
				state_d = AGD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= AGD_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// bus clock enable
	// ----------------------------------------------------------------
	// nothing here looks at sleep: the block runs whenever clocked
	always_ff @(posedge clk) begin
		if (!nrst) begin
			clk_on_q <= CLK_ON_RST; // R11
		end else begin
			clk_on_q <= guard_bus_clock_on; // R10
		end
	end

	// ----------------------------------------------------------------
	// protection vector
	// ----------------------------------------------------------------
	// a double protect still applies its other bits; the result is the
	// same as writing only the fresh bits, so nothing is lost
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prot_q <= AGD_PROT_RST; // R13
		end else if (acc && pwrite && clk_on_q) begin
			if (hit_set) begin
				prot_q <= prot_q | wmask; // R3 R5
			end else if (hit_clr) begin
				prot_q <= prot_q & ~wmask; // R2 R5
			end
		end
	end

	// ----------------------------------------------------------------
	// answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && err_now; // R15
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata_q <= '0;
		end else if (acc && !pwrite && mapped && clk_on_q) begin
			prdata_q <= prot_q; // R4
		end else begin
			prdata_q <= '0;
		end
	end

	// ----------------------------------------------------------------
	// peripheral write checker
	// ----------------------------------------------------------------
	assign chk_bus.req = per_req;
	assign chk_bus.wr = per_write;
	assign chk_bus.dbg = per_debug;
	assign chk_bus.idx = per_idx;
	assign chk_bus.prot = prot_q;

	agd_check u_check (
		.clk(clk),
		.nrst(nrst),
		.c(chk_bus.chk)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign guard_bus_clock = clk_on_q;
	assign per_ok = chk_bus.ok;
	assign per_err = chk_bus.err;
	assign prot_bits = prot_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_set_wr;
		acc && pwrite && hit_set && clk_on_q;
	endsequence
	sequence s_clr_wr;
		acc && pwrite && hit_clr && clk_on_q;
	endsequence

	set_bits_a: assert property (@(posedge clk) disable iff (!nrst) // R3
		s_set_wr |=> ((prot_q & $past(wmask)) == $past(wmask)))
		else $error("set write did not protect");
	clr_bits_a: assert property (@(posedge clk) disable iff (!nrst) // R2
		s_clr_wr |=> ((prot_q & $past(wmask)) == '0))
		else $error("clear write did not unprotect");
	zero_bits_a: assert property (@(posedge clk) disable iff (!nrst) // R5
		s_set_wr or s_clr_wr |=>
		((prot_q & ~$past(wmask)) == ($past(prot_q) & ~$past(wmask))))
		else $error("unwritten guard bit changed");
	dbl_set_err_a: assert property (@(posedge clk) disable iff (!nrst) // R7
		s_set_wr and (!pdebug && (wmask & prot_q) != '0)
		|=> pready && pslverr)
		else $error("double protect not reported");
	dbl_clr_err_a: assert property (@(posedge clk) disable iff (!nrst) // R8
		s_clr_wr and (!pdebug && (wmask & ~prot_q) != '0)
		|=> pready && pslverr)
		else $error("double unprotect not reported");
	read_mirror_a: assert property (@(posedge clk) disable iff (!nrst) // R4
		acc && !pwrite && mapped && clk_on_q |=> prdata == $past(prot_q))
		else $error("read data differs from guard vector");
	ready_once_a: assert property (@(posedge clk) disable iff (!nrst) // R15
		acc |=> pready ##1 !pready)
		else $error("answer not a single cycle");
	impl_only_a: assert property (@(posedge clk) disable iff (!nrst) // R13
		(prot_q & ~IMPL_MASK) == '0)
		else $error("unimplemented guard bit set");

endmodule : agd_ctrl

//--- verification/agd_master.sv
// bus master model standing in for the processor and the debugger
`timescale 1ns/1ps
module agd_master
	import agd_pkg::*;
(
	input wire logic clk, // bus clock
	output logic psel, // select
	output logic penable, // access phase
	output logic pwrite, // direction
	output logic [AGD_AW-1:0] paddr, // byte address
	output logic [AGD_DW-1:0] pwdata, // write data
	output logic [3:0] pstrb, // byte lanes
	output logic pdebug, // debugger access
	input wire logic [AGD_DW-1:0] prdata, // read data
	input wire logic pready, // done
	input wire logic pslverr // error
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		pdebug = 1'b0;
	end

	// request held until pready is sampled high or 8 edges pass; released data is
	// inverted so a stale value can never look valid
	task automatic xfer(input logic w, input logic [AGD_AW-1:0] a,
		input logic [AGD_DW-1:0] d, input logic [3:0] s, input logic dbg,
		output logic [AGD_DW-1:0] rd, output logic err, output logic to);
		to = 1'b1;
		rd = '0;
		err = 1'b0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		pdebug <= dbg;
		@(posedge clk);
		penable <= 1'b1;
		for (int i = 0; i < 8 && to; i++) begin
			@(posedge clk);
			if (pready) begin
				to = 1'b0;
				rd = prdata;
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
endmodule : agd_master

//--- verification/test_agd_ctrl.sv
// self-checking bench for the access guard controller
`timescale 1ns/1ps
module test_agd_ctrl;
	import agd_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel, penable, pwrite, pdebug, pready, pslverr, err, to;
	logic [AGD_AW-1:0] paddr;
	logic [AGD_DW-1:0] pwdata, prdata, prot_bits, rd;
	logic [3:0] pstrb;
	logic clk_on, generic_clock_guard_bit, per_req, per_write, per_debug, per_ok, per_err;
	logic [AGD_IDX_W-1:0] per_idx;
	int fails = 0;
	int total_checks = 0;
	localparam logic [AGD_AW-1:0] CL = AGD_OFF_PROTECT_CLEAR;
	localparam logic [AGD_AW-1:0] ST = AGD_OFF_PROTECT_SET;

	always #2.5 clk = ~clk;

	agd_master i_agd_master (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pdebug(pdebug), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	agd_ctrl i_agd_ctrl (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pdebug(pdebug), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .guard_bus_clock_on(clk_on),
		.guard_bus_clock(generic_clock_guard_bit), .per_req(per_req), .per_write(per_write),
		.per_debug(per_debug), .per_idx(per_idx), .per_ok(per_ok),
		.per_err(per_err), .prot_bits(prot_bits));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (fails == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [AGD_DW-1:0] seen,
		input logic [AGD_DW-1:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t %s got %h want %h", $time, msg, seen, exp);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [AGD_AW-1:0] a,
		input logic [AGD_DW-1:0] d, input logic [3:0] s, input logic dbg,
		input logic e_err);
		i_agd_master.xfer(w, a, d, s, dbg, rd, err, to);
		if (to) begin
			fails++;
			stop_test();
		end
		chk(err, e_err, "slave error");
	endtask : acc

	task automatic rdv(input logic [AGD_DW-1:0] e);
		acc(1'b0, CL, '0, 4'hf, 1'b0, 1'b0);
		chk(rd, e, "clear view");
		acc(1'b0, ST, '0, 4'hf, 1'b0, 1'b0);
		chk(rd, e, "set view");
		chk(prot_bits, e, "vector");
	endtask : rdv

	task automatic pchk(input int i, input logic w, input logic dbg,
		input logic e_err);
		@(posedge clk);
		per_req <= 1'b1;
		per_idx <= AGD_IDX_W'(i);
		per_write <= w;
		per_debug <= dbg;
		@(posedge clk);
		per_req <= 1'b0;
		per_idx <= ~AGD_IDX_W'(i);
		#1;
		chk(per_err, e_err, "peripheral refused");
		chk(per_ok, !e_err, "peripheral allowed");
	endtask : pchk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk(generic_clock_guard_bit, 1'b1, "bus clock enable");
		rdv(AGD_PROT_RST);
	endtask : t_reset

	task automatic t_set();
		acc(1'b1, ST, 32'hffff_ffff, 4'b0001, 1'b0, 1'b0);
		rdv(AGD_MASK0);
		acc(1'b1, ST, 32'h0000_0002, 4'hf, 1'b0, 1'b1);
		acc(1'b1, ST, 32'h0000_0002, 4'hf, 1'b1, 1'b0);
		rdv(AGD_MASK0);
	endtask : t_set

	task automatic t_per();
		pchk(AGD_WATCHDOG_GUARD_BIT, 1'b1, 1'b0, 1'b1);
		pchk(AGD_WATCHDOG_GUARD_BIT, 1'b1, 1'b1, 1'b0);
		pchk(AGD_WATCHDOG_GUARD_BIT, 1'b0, 1'b0, 1'b0);
		pchk(0, 1'b1, 1'b0, 1'b0);
	endtask : t_per

	task automatic t_clear();
		acc(1'b1, CL, 32'h0000_007e, 4'b0010, 1'b0, 1'b0);
		rdv(AGD_MASK0);
		acc(1'b1, CL, 32'h0000_0004, 4'hf, 1'b0, 1'b0);
		rdv(AGD_MASK0 & ~32'h0000_0004);
		acc(1'b1, CL, 32'h0000_0004, 4'hf, 1'b0, 1'b1);
		pchk(AGD_SYSTEM_CONTROL_GUARD_BIT, 1'b1, 1'b0, 1'b0);
		rdv(AGD_MASK0 & ~32'h0000_0004);
		acc(1'b1, ST, 32'h0000_0004, 4'b0011, 1'b0, 1'b0);
		rdv(AGD_MASK0);
	endtask : t_clear

	task automatic t_unmapped();
		acc(1'b1, 8'h08, 32'h0000_0000, 4'hf, 1'b0, 1'b1);
		acc(1'b0, 8'h0c, 32'h0000_0000, 4'hf, 1'b0, 1'b1);
	endtask : t_unmapped

	// with its bus clock off the registers refuse, the checker goes on
	task automatic t_clkoff();
		@(posedge clk);
		clk_on <= 1'b0;
		repeat (2) @(posedge clk);
		chk(generic_clock_guard_bit, 1'b0, "bus clock off");
		acc(1'b1, CL, 32'h0000_007e, 4'hf, 1'b0, 1'b1);
		pchk(AGD_EXT_IRQ_UNIT_GUARD_BIT, 1'b1, 1'b0, 1'b1);
		@(posedge clk);
		clk_on <= 1'b1;
		repeat (2) @(posedge clk);
		rdv(AGD_MASK0);
	endtask : t_clkoff

	// mid-run reset with the enable low: reset must win over the enable
	task automatic t_rerst();
		@(posedge clk);
		nrst <= 1'b0;
		clk_on <= 1'b0;
		repeat (2) @(posedge clk);
		chk(generic_clock_guard_bit, 1'b1, "reset bus clock enable");
		chk(prot_bits, AGD_PROT_RST, "reset vector");
		@(posedge clk);
		nrst <= 1'b1;
		clk_on <= 1'b1;
		rdv(AGD_PROT_RST);
	endtask : t_rerst

	initial begin
		clk_on = 1'b1;
		per_req = 1'b0;
		per_write = 1'b0;
		per_debug = 1'b0;
		per_idx = '0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_set();
		t_per();
		t_clear();
		t_unmapped();
		t_clkoff();
		t_rerst();
		stop_test();
	end
endmodule : test_agd_ctrl
